// File: hw/mpcb_bank.v
`timescale 1ns/10ps
`default_nettype none
`include "mpcb_defs.vh"
module mpcb_bank #(
    parameter MS_CYCLES = `MPCB_MS_CYCLES
) (
    input wire clock,
    input wire reset,
    input wire wr_en,
    input wire [3:0] wr_index,
    input wire [15:0] wr_data,
    input wire [3:0] rd_index,
    output reg [15:0] rd_data,
    input wire [15:0] elec_freq_tenth_hz,
    input wire elec_cycle_pulse,
    input wire [7:0] phase_current_pct,
    input wire [7:0] brake_current_pct,
    input wire desync_fault,
    input wire [9:0] password_try,
    output reg low_speed_fault,
    output reg high_speed_fault,
    output reg over_current_limit,
    output reg soft_current_protect,
    output reg [3:0] supply_undervolt_threshold_tenth_v,
    output reg [8:0] hold_ramp_pct_x4,
    output reg speed_pulse_out,
    output reg [3:0] speed_integral_shift,
    output reg [3:0] current_prop_shift,
    output reg [3:0] current_integral_shift,
    output reg [3:0] angle_prop_shift,
    output reg [3:0] angle_integral_shift,
    output reg restart_ramp_spread,
    output reg memory_unlocked,
    output reg [9:0] winding_inductance,
    output reg motor_stopped,
    output reg desync_hold_active,
    output reg [5:0] field_weak_current,
    output reg deadtime_comp_enable,
    output reg [3:0] deadtime_comp_gain,
    output reg [3:0] deadtime_comp_ratio
);
    wire [15:0] w6, w7, w8, w9, w10, w11, w12, w13, w14;

    // one stored word per config index; each masks its own unused bits
    mpcb_cfg_word #(
        .INDEX(`MPCB_IDX_SPEED),
        .MASK(`MPCB_MASK_SPEED)
    ) u_w6 (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_en),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .value(w6)
    );
    mpcb_cfg_word #(
        .INDEX(`MPCB_IDX_CURR),
        .MASK(`MPCB_MASK_CURR)
    ) u_w7 (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_en),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .value(w7)
    );
    mpcb_cfg_word #(
        .INDEX(`MPCB_IDX_SGAIN),
        .MASK(`MPCB_MASK_SGAIN)
    ) u_w8 (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_en),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .value(w8)
    );
    mpcb_cfg_word #(
        .INDEX(`MPCB_IDX_CGAIN),
        .MASK(`MPCB_MASK_CGAIN)
    ) u_w9 (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_en),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .value(w9)
    );
    mpcb_cfg_word #(
        .INDEX(`MPCB_IDX_AGAIN),
        .MASK(`MPCB_MASK_AGAIN)
    ) u_w10 (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_en),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .value(w10)
    );
    mpcb_cfg_word #(
        .INDEX(`MPCB_IDX_PWD),
        .MASK(`MPCB_MASK_PWD)
    ) u_w11 (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_en),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .value(w11)
    );
    mpcb_cfg_word #(
        .INDEX(`MPCB_IDX_IND),
        .MASK(`MPCB_MASK_IND)
    ) u_w12 (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_en),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .value(w12)
    );
    mpcb_cfg_word #(
        .INDEX(`MPCB_IDX_FIELD),
        .MASK(`MPCB_MASK_FIELD)
    ) u_w13 (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_en),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .value(w13)
    );
    mpcb_cfg_word #(
        .INDEX(`MPCB_IDX_DTC),
        .MASK(`MPCB_MASK_DTC)
    ) u_w14 (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_en),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .value(w14)
    );

    // read mux; unmapped index reads zero
    always @(posedge clock) begin
        if (reset) begin
            rd_data <= 16'h0000;
        end else begin
            case (rd_index)
                `MPCB_IDX_SPEED: rd_data <= w6;
                `MPCB_IDX_CURR: rd_data <= w7;
                `MPCB_IDX_SGAIN: rd_data <= w8;
                `MPCB_IDX_CGAIN: rd_data <= w9;
                `MPCB_IDX_AGAIN: rd_data <= w10;
                `MPCB_IDX_PWD: rd_data <= w11;
                `MPCB_IDX_IND: rd_data <= w12;
                `MPCB_IDX_FIELD: rd_data <= w13;
                `MPCB_IDX_DTC: rd_data <= w14;
                default: rd_data <= 16'h0000;
            endcase
        end
    end

    // thresholds in 0.1 Hz and percent units
    wire [5:0] low_field = w6[9:4];
    wire [3:0] high_field = w6[3:0];
    wire [4:0] imax_field = w7[9:5];
    wire [4:0] soft_field = w7[4:0];
    wire [15:0] low_thr = {10'h000, low_field} * `MPCB_LS_STEP;
    wire [15:0] high_thr = {12'h000, high_field} * `MPCB_HS_STEP;
    wire [7:0] imax_pct = `MPCB_CUR_BASE + {2'h0, imax_field, 1'b0};
    wire [7:0] soft_pct = `MPCB_CUR_BASE + {2'h0, soft_field, 1'b0};
    // brake threshold in sixteenth percent: (n+1)*6.25% of imax
    wire [15:0] brake_thr_x16 = {14'h0000, w13[9:8]} * {8'h00, imax_pct}
        + {8'h00, imax_pct};

    // hold time select
    reg [15:0] hold_ms;
    always @* begin
        case (w13[7:6])
            2'b00: hold_ms = `MPCB_HOLD_800;
            2'b01: hold_ms = `MPCB_HOLD_400;
            2'b10: hold_ms = `MPCB_HOLD_200;
            2'b11: hold_ms = `MPCB_HOLD_100;
            default: hold_ms = `MPCB_HOLD_800;
        endcase
    end

    wire hold_done;
    mpcb_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_hold (
        .clock(clock),
        .reset(reset),
        .run(desync_hold_active),
        .target_ms(hold_ms),
        .done(hold_done)
    );

    reg [1:0] pulse_div_q;
    always @(posedge clock) begin
        if (reset) begin
            low_speed_fault <= 1'b0;
            high_speed_fault <= 1'b0;
            over_current_limit <= 1'b0;
            soft_current_protect <= 1'b0;
            supply_undervolt_threshold_tenth_v <= `MPCB_UV_LOW;
            hold_ramp_pct_x4 <= 9'h000;
            speed_pulse_out <= 1'b0;
            pulse_div_q <= 2'h0;
            speed_integral_shift <= 4'h0;
            current_prop_shift <= 4'h0;
            current_integral_shift <= 4'h0;
            angle_prop_shift <= 4'h0;
            angle_integral_shift <= 4'h0;
            restart_ramp_spread <= 1'b0;
            memory_unlocked <= 1'b0;
            winding_inductance <= 10'h000;
            motor_stopped <= 1'b0;
            desync_hold_active <= 1'b0;
            field_weak_current <= 6'h00;
            deadtime_comp_enable <= 1'b0;
            deadtime_comp_gain <= 4'h0;
            deadtime_comp_ratio <= 4'h0;
        end else begin
            // limit comparisons, registered one edge after the word
            low_speed_fault <= (low_field != 6'h00) && (elec_freq_tenth_hz < low_thr);
            high_speed_fault <= (high_field != 4'h0) && (elec_freq_tenth_hz > high_thr);
            over_current_limit <= phase_current_pct >= imax_pct;
            soft_current_protect <= (soft_field != 5'h00) && (phase_current_pct >= soft_pct);
            supply_undervolt_threshold_tenth_v <= w8[9] ? `MPCB_UV_HIGH : `MPCB_UV_LOW;
            hold_ramp_pct_x4 <= {5'h00, w8[8:5]} * `MPCB_HR_STEP;
            // elec_cycle_pulse comes three times per electrical cycle; select clear
            // toggles on every third one (x1), select set on every one (x3)
            if (elec_cycle_pulse) begin
                if (w8[4]) begin
                    speed_pulse_out <= ~speed_pulse_out;
                end else begin
                    pulse_div_q <= (pulse_div_q == `MPCB_FG_DIV_LAST) ? 2'h0 : pulse_div_q + 2'h1;
                    if (pulse_div_q == `MPCB_FG_DIV_LAST) begin
                        speed_pulse_out <= ~speed_pulse_out;
                    end
                end
            end
            // shift codes: field value; gain = 2^(shift-7)
            speed_integral_shift <= w8[3:0];
            current_prop_shift <= w9[8:5];
            current_integral_shift <= w9[3:0];
            angle_prop_shift <= w10[8:5];
            angle_integral_shift <= w10[3:0];
            restart_ramp_spread <= w9[4];
            memory_unlocked <= password_try == w11[9:0];
            winding_inductance <= w12[9:0];
            motor_stopped <= {4'h0, brake_current_pct, 4'h0} < brake_thr_x16;
            // a new fault wins over the end of the hold; a repeat does not restart it
            if (desync_fault) begin
                desync_hold_active <= 1'b1;
            end else if (hold_done) begin
                desync_hold_active <= 1'b0;
            end
            // raw fields for the field and dead time blocks
            field_weak_current <= w13[5:0];
            deadtime_comp_enable <= w14[9];
            deadtime_comp_gain <= w14[7:4];
            deadtime_comp_ratio <= w14[3:0];
        end
    end
endmodule
`default_nettype wire

// File: hw/mpcb_cfg_word.v
`timescale 1ns/10ps
`default_nettype none
// one configuration word; only bits in the mask are stored
module mpcb_cfg_word #(
    parameter [3:0] INDEX = 4'h0,
    parameter [15:0] MASK = 16'hffff
) (
    input wire clock,
    input wire reset,
    input wire wr_en,
    input wire [3:0] wr_index,
    input wire [15:0] wr_data,
    output wire [15:0] value
);
`include "mpcb_defs.vh"
    reg [15:0] word_q;
    always @(posedge clock) begin
        if (reset) begin
            word_q <= `MPCB_RST_WORD;
        end else if (wr_en && wr_index == INDEX) begin
            word_q <= wr_data & MASK;
        end
    end
    assign value = word_q & MASK;
endmodule
`default_nettype wire

// File: hw/mpcb_defs.vh
`ifndef MPCB_DEFS_VH
`define MPCB_DEFS_VH

`define MPCB_IDX_SPEED 4'h6
`define MPCB_IDX_CURR 4'h7
`define MPCB_IDX_SGAIN 4'h8
`define MPCB_IDX_CGAIN 4'h9
`define MPCB_IDX_AGAIN 4'ha
`define MPCB_IDX_PWD 4'hb
`define MPCB_IDX_IND 4'hc
`define MPCB_IDX_FIELD 4'hd
`define MPCB_IDX_DTC 4'he

`define MPCB_MASK_SPEED 16'h03ff
`define MPCB_MASK_CURR 16'h03ff
`define MPCB_MASK_SGAIN 16'h03ff
`define MPCB_MASK_CGAIN 16'h01ff
`define MPCB_MASK_AGAIN 16'h01ef
`define MPCB_MASK_PWD 16'h03ff
`define MPCB_MASK_IND 16'h03ff
`define MPCB_MASK_FIELD 16'h03ff
`define MPCB_MASK_DTC 16'h02ff

`define MPCB_RST_WORD 16'h0000

`define MPCB_LS_STEP 16'h0008
`define MPCB_HS_STEP 16'h0400
`define MPCB_HR_STEP 9'h019
`define MPCB_UV_LOW 4'h3
`define MPCB_UV_HIGH 4'h6
`define MPCB_FG_DIV_LAST 2'h2

`define MPCB_CUR_BASE 8'h26
`define MPCB_GAIN_BIAS 5'h07
`define MPCB_HOLD_800 16'h0320
`define MPCB_HOLD_400 16'h0190
`define MPCB_HOLD_200 16'h00c8
`define MPCB_HOLD_100 16'h0064
`define MPCB_CLK_HZ 200000000
`define MPCB_MS_CYCLES (`MPCB_CLK_HZ / 1000)

`endif

// File: hw/mpcb_ms_timer.v
`timescale 1ns/10ps
`default_nettype none
// counts whole milliseconds while run is high, done pulses at target
module mpcb_ms_timer #(
    parameter MS_CYCLES = 200000
) (
    input wire clock,
    input wire reset,
    input wire run,
    input wire [15:0] target_ms,
    output wire done
);
    reg [31:0] tick_q;
    reg [15:0] ms_q;
    wire ms_tick;
    assign ms_tick = run && (tick_q == MS_CYCLES - 1);
    always @(posedge clock) begin
        if (reset || !run) begin
            tick_q <= 32'h0000_0000;
            ms_q <= 16'h0000;
        end else if (ms_tick) begin
            tick_q <= 32'h0000_0000;
            ms_q <= ms_q + 16'h0001;
        end else begin
            tick_q <= tick_q + 32'h0000_0001;
        end
    end
    assign done = ms_tick && (ms_q + 16'h0001 == target_ms);
endmodule
`default_nettype wire

// File: verification/mpcb_bank_sva.sv
`timescale 1ns/10ps
`default_nettype none
module mpcb_bank_chk #(
    parameter MS_CYCLES = 200000
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [3:0] wr_index,
    input wire logic [15:0] wr_data,
    input wire logic [3:0] rd_index,
    input wire logic [15:0] rd_data,
    input wire logic elec_cycle_pulse,
    input wire logic desync_fault,
    input wire logic [3:0] supply_undervolt_threshold_tenth_v,
    input wire logic [8:0] hold_ramp_pct_x4,
    input wire logic speed_pulse_out,
    input wire logic [3:0] speed_integral_shift,
    input wire logic [3:0] angle_prop_shift,
    input wire logic restart_ramp_spread,
    input wire logic [9:0] winding_inductance,
    input wire logic desync_hold_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_uv; wr_en && wr_index == 4'h8 |-> ##2
        supply_undervolt_threshold_tenth_v == ($past(wr_data[9], 2) ? 4'h6 : 4'h3); endproperty
    a_uv: assert property (p_uv) else $error("undervolt threshold wrong");
    property p_ramp; wr_en && wr_index == 4'h8 |-> ##2
        hold_ramp_pct_x4 == {5'h00, $past(wr_data[8:5], 2)} * 9'h019; endproperty
    a_ramp: assert property (p_ramp) else $error("hold ramp wrong");
    property p_si; wr_en && wr_index == 4'h8 |-> ##2
        speed_integral_shift == $past(wr_data[3:0], 2); endproperty
    a_si: assert property (p_si) else $error("speed gain wrong");
    property p_etr; wr_en && wr_index == 4'h9 |-> ##2
        restart_ramp_spread == $past(wr_data[4], 2); endproperty
    a_etr: assert property (p_etr) else $error("restart select wrong");
    property p_tp; wr_en && wr_index == 4'ha |-> ##2
        angle_prop_shift == $past(wr_data[8:5], 2); endproperty
    a_tp: assert property (p_tp) else $error("angle gain wrong");
    property p_lw; wr_en && wr_index == 4'hc |-> ##2
        winding_inductance == $past(wr_data[9:0], 2); endproperty
    a_lw: assert property (p_lw) else $error("inductance wrong");
    property p_unmap; rd_index < 4'h6 || rd_index > 4'he |=> rd_data == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_top; rd_data[15:10] == 6'h00; endproperty
    a_top: assert property (p_top) else $error("upper bits not zero");
    property p_fg; $changed(speed_pulse_out) |->
        $past(elec_cycle_pulse) || $past(elec_cycle_pulse, 2); endproperty
    a_fg: assert property (p_fg) else $error("pulse output moved alone");
    property p_los; desync_fault |-> ##[1:2] desync_hold_active; endproperty
    a_los: assert property (p_los) else $error("hold not started");
endmodule
bind mpcb_bank mpcb_bank_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clock, .reset, .wr_en,
    .wr_index, .wr_data, .rd_index, .rd_data, .elec_cycle_pulse, .desync_fault,
    .supply_undervolt_threshold_tenth_v, .hold_ramp_pct_x4, .speed_pulse_out,
    .speed_integral_shift, .angle_prop_shift, .restart_ramp_spread, .winding_inductance,
    .desync_hold_active);
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clock = 1'b0, reset = 1'b1, wr_en = 1'b0, elec_cycle_pulse = 1'b0, desync_fault = 1'b0;
    logic [3:0] wr_index = 4'h0, rd_index = 4'h0;
    logic [15:0] wr_data = 16'h0000, elec_freq_tenth_hz = 16'h0000;
    logic [7:0] phase_current_pct = 8'h00, brake_current_pct = 8'h00;
    logic [9:0] password_try = 10'h000;
    wire [15:0] rd_data;
    wire [3:0] uv, sis, cps, cis, aps, ais, dg, dr;
    wire [8:0] hr;
    wire [9:0] lw;
    wire [5:0] fw;
    wire lo, hi, oc, sc, spo, rs, unl, stp, act, dte;
    int fails = 0, tests_run = 0, i;
    logic p0;
    logic [15:0] msk [6:14] = '{16'h03ff, 16'h03ff, 16'h03ff, 16'h01ff, 16'h01ef, 16'h03ff,
        16'h03ff, 16'h03ff, 16'h02ff};
    mpcb_bank #(.MS_CYCLES(10)) DUT (.clock, .reset, .wr_en, .wr_index, .wr_data, .rd_index,
        .rd_data, .elec_freq_tenth_hz, .elec_cycle_pulse, .phase_current_pct,
        .brake_current_pct, .desync_fault, .password_try, .low_speed_fault(lo),
        .high_speed_fault(hi), .over_current_limit(oc), .soft_current_protect(sc),
        .supply_undervolt_threshold_tenth_v(uv), .hold_ramp_pct_x4(hr), .speed_pulse_out(spo),
        .speed_integral_shift(sis), .current_prop_shift(cps), .current_integral_shift(cis),
        .angle_prop_shift(aps), .angle_integral_shift(ais), .restart_ramp_spread(rs),
        .memory_unlocked(unl), .winding_inductance(lw), .motor_stopped(stp),
        .desync_hold_active(act), .field_weak_current(fw), .deadtime_comp_enable(dte),
        .deadtime_comp_gain(dg), .deadtime_comp_ratio(dr));
    always #2.5 clock = ~clock;
    task step(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] x, input logic [15:0] d);
        wr_en = 1'b1;
        wr_index = x;
        wr_data = d;
        step(1);
        wr_en = 1'b0;
        step(3);
    endtask
    task rd(input logic [3:0] x, input logic [15:0] e);
        rd_index = x;
        step(2);
        cmp(rd_data, e);
    endtask
    task fq(input logic [15:0] f, input logic l, input logic h);
        elec_freq_tenth_hz = f;
        step(3);
        cmp(lo, l);
        cmp(hi, h);
    endtask
    task cur(input logic [7:0] p, input logic o, input logic s);
        phase_current_pct = p;
        step(3);
        cmp(oc, o);
        cmp(sc, s);
    endtask
    task pls(input int n);
        repeat (n) begin
            elec_cycle_pulse = 1'b1;
            step(1);
            elec_cycle_pulse = 1'b0;
            step(2);
        end
    endtask
    task t_regs;
        cmp(uv, 4'h3);
        for (i = 6; i < 15; i++) rd(i[3:0], 16'h0000);
        for (i = 6; i < 15; i++) begin
            wr(i[3:0], 16'hffff);
            rd(i[3:0], msk[i]);
        end
        wr(4'h5, 16'hffff);
        rd(4'h5, 16'h0000);
        wr(4'hf, 16'hffff);
        rd(4'hf, 16'h0000);
    endtask
    task t_speed;
        wr(4'h6, 16'h0021);
        fq(16'd15, 1'b1, 1'b0);
        fq(16'd16, 1'b0, 1'b0);
        fq(16'd1025, 1'b0, 1'b1);
        fq(16'd1024, 1'b0, 1'b0);
        wr(4'h6, 16'h0000);
        fq(16'd0, 1'b0, 1'b0);
        fq(16'hffff, 1'b0, 1'b0);
    endtask
    task t_cur;
        wr(4'h7, 16'h00d5);
        cur(8'd49, 1'b0, 1'b0);
        cur(8'd50, 1'b1, 1'b0);
        cur(8'd79, 1'b1, 1'b0);
        cur(8'd80, 1'b1, 1'b1);
        wr(4'h7, 16'h00c0);
        cur(8'hff, 1'b1, 1'b0);
    endtask
    task t_misc;
        wr(4'h8, 16'h0306);
        cmp(uv, 4'h6);
        cmp(hr, 8'hc8);
        cmp(sis, 4'h6);
        p0 = spo;
        pls(2);
        cmp(spo, p0);
        pls(1);
        cmp(spo, !p0);
        wr(4'h8, 16'h01f0);
        cmp(uv, 4'h3);
        cmp(hr, 16'h0177);
        pls(1);
        cmp(spo, p0);
        wr(4'h9, 16'h01f0);
        cmp({cps, cis, 3'h0, rs}, 16'h0f01);
        wr(4'ha, 16'h0123);
        cmp({aps, ais}, 16'h0093);
        wr(4'hc, 16'h00c8);
        cmp(lw, 16'd200);
        wr(4'hb, 16'h02a5);
        password_try = 10'h2a5;
        step(3);
        cmp(unl, 1'b1);
        password_try = 10'h2a4;
        step(3);
        cmp(unl, 1'b0);
        wr(4'he, 16'h03a5);
        cmp({dte, 3'h0, dg, dr}, 16'h08a5);
        wr(4'hd, 16'h0115);
        cmp(fw, 16'h0015);
        brake_current_pct = 8'd6;
        step(3);
        cmp(stp, 1'b1);
        brake_current_pct = 8'd7;
        step(3);
        cmp(stp, 1'b0);
    endtask
    task t_los;
        for (i = 0; i < 4; i++) begin
            wr(4'hd, 16'(i << 6));
            desync_fault = 1'b1;
            step(1);
            desync_fault = 1'b0;
            step(2);
            cmp(act, 1'b1);
            step((800 >> i) * 10 - 20);
            cmp(act, 1'b1);
            step(40);
            cmp(act, 1'b0);
        end
    endtask
    task summarize;
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        step(5);
        reset = 1'b0;
        t_regs;
        t_speed;
        t_cur;
        t_misc;
        t_los;
        summarize;
    end
    initial begin
        #200000;
        fails++;
        summarize;
    end
endmodule
`default_nettype wire
